/* File: include/msbc_defines.svh */
// constants of the memory self-test controller: counts, offsets, fields, reset values
`ifndef MSBC_DEFINES_SVH
`define MSBC_DEFINES_SVH

// engine population
`define MSBC_NUM_TOTAL      80
`define MSBC_NUM_SOC        56
`define MSBC_NUM_VISIBLE    48
`define MSBC_ENG_PER_CORE   3
`define MSBC_NUM_CORES      8

// apb register byte offsets
`define MSBC_OFF_SKIP_LO    12'h000
`define MSBC_OFF_SKIP_HI    12'h004
`define MSBC_OFF_MODE       12'h008
`define MSBC_OFF_CMD        12'h00c
`define MSBC_OFF_STATUS     12'h010
`define MSBC_OFF_DONE_LO    12'h014
`define MSBC_OFF_DONE_HI    12'h018
`define MSBC_OFF_FAIL_LO    12'h01c
`define MSBC_OFF_FAIL_HI    12'h020

// mode register fields
`define MSBC_MODE_W         4
`define MSBC_MODE_LOOP      3
`define MSBC_MODE_USER      2
`define MSBC_MODE_INIT      1
`define MSBC_MODE_PAR       0

// summary register fields
`define MSBC_RES_W          2
`define MSBC_RES_DONE       1
`define MSBC_RES_FAIL       0

// command register fields
`define MSBC_CMD_START      0
`define MSBC_CMD_ABORT      1

// status register fields above the summary bits
`define MSBC_STAT_RUN       2
`define MSBC_STAT_DEF       3

// reset values
`define MSBC_RST_MODE       4'h2
`define MSBC_RST_SKIP       48'h0000_0000_0000

`endif

/* File: include/msbc_pkg.sv */
// types shared by the memory self-test controller files
package msbc_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      MSBC_SEQ_IDLE = 2'b00,
      MSBC_SEQ_SCAN = 2'b01,
      MSBC_SEQ_WAIT = 2'b10,
      MSBC_SEQ_PAR  = 2'b11
   } msbc_seq_e;

   // test-access instructions as decoded by the tap outside
   typedef enum logic [3:0] {
      MSBC_I_NONE    = 4'h0,
      MSBC_I_SKIP    = 4'h1,
      MSBC_I_MODE    = 4'h2,
      MSBC_I_START   = 4'h3,
      MSBC_I_RESULT  = 4'h4,
      MSBC_I_DIAG    = 4'h5,
      MSBC_I_DONE    = 4'h6,
      MSBC_I_FAIL    = 4'h7,
      MSBC_I_ABORT   = 4'h8
   } msbc_instr_e;

endpackage

/* File: logic/msbc_seq.sv */
// start sequencer for the memory test engines
`timescale 1ns/1ps
`include "msbc_defines.svh"

module msbc_seq
   import msbc_pkg::*;
#(
   parameter int NENG = `MSBC_NUM_VISIBLE
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            go,        // launch pulse
   input  wire logic            parallel,  // mode of this launch
   input  wire logic            abort,     // stop pulse
   input  wire logic [NENG-1:0] skip,      // 1 excludes an engine
   input  wire logic [NENG-1:0] eng_done,
   output logic      [NENG-1:0] eng_start,
   output logic                 busy
);

   localparam int IW = $clog2(NENG);

   msbc_seq_e        state;       // sequencer state
   msbc_seq_e        next_state;
   logic [NENG-1:0]  next_start;
   logic [IW-1:0]    idx;         // engine being run serially
   logic [IW-1:0]    next_idx;
   logic [IW:0]      found;       // search result, msb = hit

   // first non-skipped engine at or above from
   function automatic logic [IW:0] find_next(input logic [NENG-1:0] msk, input logic [IW-1:0] from);
      logic [IW:0] r;
      r = '0;
      for (int i = NENG - 1; i >= 0; i--) begin
         if (i >= int'(from) && !msk[i]) begin
            r = {1'b1, IW'(i)};
         end
      end
      return r;
   endfunction

   assign found = find_next(skip, idx);
   assign busy  = (state != MSBC_SEQ_IDLE);

   // next state; starts are held as levels once raised
   always_comb begin
      next_state = state;
      next_start = eng_start;
      next_idx   = idx;
      if (abort) begin
         next_state = MSBC_SEQ_IDLE;
         next_start = '0;
         next_idx   = '0;
      end else if (go) begin
         next_start = '0;                       // a fresh run drops stale starts
         next_idx   = '0;
         next_state = parallel ? MSBC_SEQ_PAR : MSBC_SEQ_SCAN;
      end else begin
         case (state)
            MSBC_SEQ_SCAN: begin
               if (found[IW]) begin
                  next_idx                = found[IW-1:0];
                  next_start[found[IW-1:0]] = 1'b1;
                  next_state              = MSBC_SEQ_WAIT;
               end else begin
                  next_state = MSBC_SEQ_IDLE;
               end
            end
            MSBC_SEQ_WAIT: begin
               // engine done must be low until its start; else it is skipped at once
               if (eng_done[idx]) begin
                  if (int'(idx) == NENG - 1) begin
                     next_state = MSBC_SEQ_IDLE;
                  end else begin
                     next_idx   = idx + IW'(1);
                     next_state = MSBC_SEQ_SCAN;
                  end
               end
            end
            MSBC_SEQ_PAR: begin
               next_start = ~skip;
               next_state = MSBC_SEQ_IDLE;
            end
            default: begin
               next_state = MSBC_SEQ_IDLE;
            end
         endcase
      end
   end

   // register the sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= MSBC_SEQ_IDLE;
         eng_start <= '0;
         idx       <= '0;
      end else begin
         state     <= next_state;
         eng_start <= next_start;
         idx       <= next_idx;
      end
   end

endmodule // msbc_seq

/* File: logic/msbc_ctrl.sv */
// memory self-test controller: test-access data registers, apb registers, engine control
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "msbc_defines.svh"

module msbc_ctrl
   import msbc_pkg::*;
#(
   parameter int NENG = `MSBC_NUM_VISIBLE
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // tap side
   input  wire logic [3:0]      tap_instr,      // current decoded instruction
   input  wire logic            tap_rti,        // level: tap in run-test/idle
   input  wire logic            tap_tlr,        // level: tap in test-logic-reset
   input  wire logic            tap_capture_dr, // pulse
   input  wire logic            tap_shift_dr,   // pulse per shifted bit
   input  wire logic            tap_update_dr,  // pulse
   input  wire logic            tap_tdi,
   output logic                 tap_tdo,
   // reset sequencer
   input  wire logic            run_default_test,
   input  wire logic            run_default_init,
   // engines
   output logic      [NENG-1:0] eng_start,
   input  wire logic [NENG-1:0] eng_done,
   input  wire logic [NENG-1:0] eng_fail,
   output logic                 init_en,        // array-initialise enable to all arrays
   output logic      [NENG-1:0] diag_shift,     // shift enable of targeted chain
   output logic                 diag_si,        // chain serial in
   input  wire logic [NENG-1:0] diag_so         // chain serial outs
);

   localparam int SRW = NENG;      // data-register shifter width
   localparam int HIW = NENG - 32; // upper word bits of 48-bit vectors

   msbc_instr_e        instr;               // instruction view
   logic [NENG-1:0]    skip;                // engine skip mask
   logic [NENG-1:0]    next_skip;
   logic [3:0]         mode;                // mode register
   logic [3:0]         next_mode;
   logic [SRW-1:0]     sr;                  // tap data shifter
   logic [SRW-1:0]     next_sr;
   logic [6:0]         sr_len;              // active length of shifter
   logic [6:0]         next_sr_len;
   logic               armed;               // start loaded, waiting for idle entry
   logic               next_armed;
   logic               rti_q;               // idle level one cycle ago
   logic               def_q;               // default requests one cycle ago
   logic [3:0]         instr_q;             // instruction one cycle ago
   logic               def_run;             // current run came from reset default
   logic               next_def_run;
   logic               def_init;            // default run is an initialise run
   logic               next_def_init;
   logic [31:0]        next_prdata;
   logic               next_tdo;
   logic               go;                  // launch pulse to sequencer
   logic               go_par;              // mode handed with the launch
   logic               abort;               // abort pulse to sequencer
   logic               busy;
   logic               all_done;
   logic               any_fail;
   logic [1:0]         result;              // summary register
   logic               wr_en;
   logic               rd_setup;
   logic               mapped;
   logic               jtag_go;
   logic               apb_go;
   logic               def_go;
   logic [NENG-1:0]    run_skip;            // mask applied to the current run

   assign instr = msbc_instr_e'(tap_instr);

   // address decode, used for the access-phase error response and write enable
   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         `MSBC_OFF_SKIP_LO, `MSBC_OFF_SKIP_HI, `MSBC_OFF_MODE, `MSBC_OFF_CMD,
         `MSBC_OFF_STATUS, `MSBC_OFF_DONE_LO, `MSBC_OFF_DONE_HI,
         `MSBC_OFF_FAIL_LO, `MSBC_OFF_FAIL_HI: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // a default run covers every engine for its whole length, not only in its launch cycle
   assign run_skip = (def_go | def_run) ? '0 : skip;
   // skipped engines count as done and cannot fail
   assign all_done = &(eng_done | run_skip);
   assign any_fail = |(eng_fail & ~run_skip);
   assign result   = {all_done, any_fail};

   // apb: read data is fetched in setup, so the access phase answers at once
   assign mapped   = is_mapped(paddr);
   assign pready   = psel & penable;
   assign pslverr  = psel & penable & ~mapped;
   assign wr_en    = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;

   // launches: tap start on idle entry, apb command, reset defaults
   assign jtag_go  = armed & tap_rti & ~rti_q;
   assign apb_go   = wr_en & (paddr == `MSBC_OFF_CMD) & pwdata[`MSBC_CMD_START];
   assign def_go   = (run_default_test | run_default_init) & ~def_q & ~busy;
   assign go       = jtag_go | apb_go | def_go;
   // defaults never run in parallel, whatever the mode says
   assign go_par   = mode[`MSBC_MODE_PAR] & ~def_go;
   // abort on entering the abort instruction or by command
   assign abort    = ((instr == MSBC_I_ABORT) & (tap_instr != instr_q))
                   | (wr_en & (paddr == `MSBC_OFF_CMD) & pwdata[`MSBC_CMD_ABORT]);

   // init enable: mode bit or a default initialise run; engine config bits act inside engines
   assign init_en  = mode[`MSBC_MODE_INIT] | (def_run & def_init);

   // diagnostic chain reaches only the non-skipped engines
   assign diag_shift = {NENG{tap_shift_dr & (instr == MSBC_I_DIAG)}} & ~skip;
   assign diag_si    = tap_tdi;

   // control state: mask, mode, shifter, launch bookkeeping
   always_comb begin
      next_skip     = skip;
      next_mode     = mode;
      next_sr       = sr;
      next_sr_len   = sr_len;
      next_armed    = armed;
      next_def_run  = def_run;
      next_def_init = def_init;
      next_prdata   = prdata;
      next_tdo      = tap_tdo;
      // capture-dr loads the instruction's register
      if (tap_capture_dr) begin
         case (instr)
            MSBC_I_RESULT: begin
               next_sr     = SRW'(result);
               next_sr_len = 7'(`MSBC_RES_W);
            end
            MSBC_I_DONE: begin
               next_sr     = eng_done;
               next_sr_len = 7'(NENG);
            end
            MSBC_I_FAIL: begin
               next_sr     = eng_fail;
               next_sr_len = 7'(NENG);
            end
            MSBC_I_SKIP: begin
               next_sr     = skip;
               next_sr_len = 7'(NENG);
            end
            MSBC_I_MODE: begin
               next_sr     = SRW'(mode);
               next_sr_len = 7'(`MSBC_MODE_W);
            end
            default: begin
               next_sr     = '0;
               next_sr_len = 7'd1;
            end
         endcase
      end else if (tap_shift_dr) begin
         // shift toward tdo; tdi enters at the top of the active length
         next_sr = sr >> 1;
         for (int i = 0; i < SRW; i++) begin
            if (i == int'(sr_len) - 1) begin
               next_sr[i] = tap_tdi;
            end
         end
      end
      // update-dr writes the loadable registers
      if (tap_update_dr && instr == MSBC_I_SKIP) begin
         next_skip = sr;
      end
      if (tap_update_dr && instr == MSBC_I_MODE) begin
         next_mode = sr[3:0];
      end
      // tdo from the shifter or the targeted engine chain
      if (instr == MSBC_I_DIAG) begin
         next_tdo = |(diag_so & ~skip);
      end else begin
         next_tdo = next_sr[0];
      end
      // start instruction arms once per entry into it
      if (instr == MSBC_I_START && tap_instr != instr_q) begin
         next_armed = 1'b1;
      end
      // tlr clears the arm but never the run itself
      if (jtag_go || abort || tap_tlr || instr != MSBC_I_START) begin
         next_armed = 1'b0;
      end
      // apb writes
      if (wr_en) begin
         case (paddr)
            `MSBC_OFF_SKIP_LO: next_skip[31:0]    = pwdata;
            `MSBC_OFF_SKIP_HI: next_skip[NENG-1:32] = pwdata[HIW-1:0];
            `MSBC_OFF_MODE:    next_mode          = pwdata[3:0];
            default: ;
         endcase
      end
      // remember whether this run came from the reset sequencer
      if (go) begin
         next_def_run  = def_go & ~jtag_go & ~apb_go;
         next_def_init = run_default_init & ~run_default_test;
      end
      if (abort) begin
         next_def_run = 1'b0;
      end
      // apb read data, latched in setup
      if (rd_setup) begin
         case (paddr)
            `MSBC_OFF_SKIP_LO: next_prdata = skip[31:0];
            `MSBC_OFF_SKIP_HI: next_prdata = 32'(skip[NENG-1:32]);
            `MSBC_OFF_MODE:    next_prdata = 32'(mode);
            `MSBC_OFF_STATUS:  next_prdata = 32'({def_run, busy, result});
            `MSBC_OFF_DONE_LO: next_prdata = eng_done[31:0];
            `MSBC_OFF_DONE_HI: next_prdata = 32'(eng_done[NENG-1:32]);
            `MSBC_OFF_FAIL_LO: next_prdata = eng_fail[31:0];
            `MSBC_OFF_FAIL_HI: next_prdata = 32'(eng_fail[NENG-1:32]);
            default:           next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // register the control state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip     <= `MSBC_RST_SKIP;
         mode     <= `MSBC_RST_MODE;
         sr       <= '0;
         sr_len   <= 7'h01;
         armed    <= 1'b0;
         rti_q    <= 1'b0;
         def_q    <= 1'b1;                 // no launch on a level held through reset
         instr_q  <= 4'h0;
         def_run  <= 1'b0;
         def_init <= 1'b0;
         prdata   <= 32'h0000_0000;
         tap_tdo  <= 1'b0;
      end else begin
         skip     <= next_skip;
         mode     <= next_mode;
         sr       <= next_sr;
         sr_len   <= next_sr_len;
         armed    <= next_armed;
         rti_q    <= tap_rti;
         def_q    <= run_default_test | run_default_init;
         instr_q  <= tap_instr;
         def_run  <= next_def_run;
         def_init <= next_def_init;
         prdata   <= next_prdata;
         tap_tdo  <= next_tdo;
      end
   end

   // start sequencer; a default run ignores the mask so it covers all arrays
   msbc_seq #(
      .NENG      (NENG)
   ) u_seq (
      .clk       (clk),
      .rst_n     (rst_n),
      .go        (go),
      .parallel  (go_par),
      .abort     (abort),
      .skip      (run_skip),
      .eng_done  (eng_done),
      .eng_start (eng_start),
      .busy      (busy)
   );

endmodule // msbc_ctrl

/* File: verification/msbc_ctrl_assertions.sv */
// port checker of the memory self-test controller
`timescale 1ns/1ps
module msbc_chk
   import msbc_pkg::*;
#(
   parameter int NENG = 48
) (
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [3:0]      tap_instr,
   input wire logic            tap_rti,
   input wire logic            tap_tlr,
   input wire logic            tap_capture_dr,
   input wire logic            tap_shift_dr,
   input wire logic            tap_tdi,
   input wire logic            tap_tdo,
   input wire logic            run_default_test,
   input wire logic            run_default_init,
   input wire logic [NENG-1:0] eng_start,
   input wire logic [NENG-1:0] eng_done,
   input wire logic [NENG-1:0] eng_fail,
   input wire logic            init_en,
   input wire logic [NENG-1:0] diag_shift,
   input wire logic            diag_si
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable && pwrite;  // apb write taken
   wire cap = tap_capture_dr;             // capture pulse
   // quiet run in reset state, nothing else may end it
   property tlr_keep;
      tap_tlr && |eng_start && !tap_rti && !psel && tap_instr != 4'h8
         && !run_default_test && !run_default_init |=> |eng_start;
   endproperty
   AST_ABT_TAP: assert property ($changed(tap_instr) && tap_instr == 4'h8 |=> eng_start == '0)
      else $error("starts kept after abort instruction");
   AST_ABT_APB: assert property (acc && paddr == 12'h00c && pwdata[1] |=> eng_start == '0)
      else $error("starts kept after abort write");
   AST_RST_INIT: assert property (!$past(rst_n) |-> init_en)
      else $error("init enable low after reset");
   AST_DIAG_EN: assert property (|diag_shift |-> tap_shift_dr && tap_instr == 4'h5)
      else $error("chain shifted outside diag");
   AST_DIAG_SI: assert property (|diag_shift |-> diag_si == tap_tdi)
      else $error("chain input differs from tdi");
   AST_RES_DONE: assert property (cap && tap_instr == 4'h4 && &eng_done ##1 tap_shift_dr |=> tap_tdo)
      else $error("summary done bit low");
   AST_RES_FAIL: assert property (cap && tap_instr == 4'h4 && eng_fail == '0 |=> !tap_tdo)
      else $error("summary fail bit high");
   AST_VEC_DONE: assert property (cap && tap_instr == 4'h6 && eng_done[0] |=> tap_tdo)
      else $error("done vector bit0 low");
   AST_VEC_FAIL: assert property (cap && tap_instr == 4'h7 && !eng_fail[0] |=> !tap_tdo)
      else $error("fail vector bit0 high");
   AST_TLR_RUN: assert property (tlr_keep)
      else $error("run stopped in reset state");
   // main scenarios reached
   cover property (cap && tap_instr == 4'h4);
   cover property ($fell(|eng_start));
   cover property ($rose(init_en));
endmodule // msbc_chk

bind msbc_ctrl msbc_chk #(.NENG(NENG)) u_msbc_chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .tap_instr(tap_instr), .tap_rti(tap_rti), .tap_tlr(tap_tlr),
   .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr), .tap_tdi(tap_tdi), .tap_tdo(tap_tdo),
   .run_default_test(run_default_test), .run_default_init(run_default_init), .eng_start(eng_start),
   .eng_done(eng_done), .eng_fail(eng_fail), .init_en(init_en), .diag_shift(diag_shift), .diag_si(diag_si)
);

/* File: verification/msbc_eng.sv */
// behavioural memory test engines facing the controller
`timescale 1ns/1ps
module msbc_eng
   import msbc_pkg::*;
#(
   parameter int NENG = 48
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic [NENG-1:0] eng_start,   // level start
   input  wire logic [NENG-1:0] fail_pat,    // engines that fail
   input  wire logic [3:0]      lat,         // base run length
   input  wire logic [NENG-1:0] diag_shift,
   input  wire logic            diag_si,
   output logic      [NENG-1:0] eng_done,
   output logic      [NENG-1:0] eng_fail,
   output logic      [NENG-1:0] diag_so
);
   logic [7:0] cnt   [NENG];  // cycles left
   logic [7:0] chain [NENG];  // engine registers
   // dropping start clears the result, so no stale done is seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_done <= '0;
         eng_fail <= '0;
         for (int i = 0; i < NENG; i++) begin
            cnt[i] <= '0;
            chain[i] <= 8'h5a;
         end
      end else begin
         for (int i = 0; i < NENG; i++) begin
            if (!eng_start[i]) begin  // idle engine
               eng_done[i] <= 1'b0;
               eng_fail[i] <= 1'b0;
               cnt[i] <= 8'(lat) + 8'(i % 3);
            end else if (cnt[i] != 8'h0) begin
               cnt[i] <= cnt[i] - 8'h1;
            end else begin  // fail only shown with done
               eng_done[i] <= 1'b1;
               eng_fail[i] <= fail_pat[i];
            end
            if (diag_shift[i]) begin
               chain[i] <= {diag_si, chain[i][7:1]};
            end
         end
      end
   end
   // chain outputs
   always_comb begin
      for (int i = 0; i < NENG; i++) begin
         diag_so[i] = chain[i][0];
      end
   end
endmodule // msbc_eng

/* File: verification/tb_top.sv */
// self-checking bench of the memory self-test controller
`timescale 1ns/1ps
module tb_top
   import msbc_pkg::*;
;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, se, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [3:0]  tap_instr = 0, lat = 1;
   logic        tap_rti = 0, tap_tlr = 0, tap_capture_dr = 0, tap_shift_dr = 0, tap_update_dr = 0;
   logic        tap_tdi = 0, tap_tdo, run_default_test = 0, run_default_init = 0, init_en, diag_si, mon = 0;
   logic [47:0] eng_start, eng_done, eng_fail, diag_shift, diag_so, fail_pat = 0, sk, v, ps = 0;
   int          seed = 32'h59251f71, err_count = 0, checked = 0, cyc = 0;
   int          q[$];  // serial start order seen
   msbc_ctrl #(.NENG(48)) u_msbc_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tap_instr(tap_instr), .tap_rti(tap_rti), .tap_tlr(tap_tlr), .tap_capture_dr(tap_capture_dr),
      .tap_shift_dr(tap_shift_dr), .tap_update_dr(tap_update_dr), .tap_tdi(tap_tdi), .tap_tdo(tap_tdo),
      .run_default_test(run_default_test), .run_default_init(run_default_init), .eng_start(eng_start),
      .eng_done(eng_done), .eng_fail(eng_fail), .init_en(init_en), .diag_shift(diag_shift),
      .diag_si(diag_si), .diag_so(diag_so));
   msbc_eng #(.NENG(48)) u_msbc_eng (.clk(clk), .rst_n(rst_n), .eng_start(eng_start), .fail_pat(fail_pat),
      .lat(lat), .diag_shift(diag_shift), .diag_si(diag_si), .eng_done(eng_done), .eng_fail(eng_fail),
      .diag_so(diag_so));
   always #2 clk = ~clk;
   // compare and count
   task automatic chk(input string nm, input logic [47:0] s, e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // expected summary: all done, any unskipped fail
   function automatic logic [1:0] rsum(input logic [47:0] f, s);
      return {1'b1, |(f & ~s)};
   endfunction
   // one apb transfer, result in r and se
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   // capture, shift n bits lsb first into v, update
   task automatic dr(input msbc_instr_e ins, input int n, input logic [47:0] d);
      tap_instr <= ins;
      @(posedge clk);
      tap_capture_dr <= 1;
      @(posedge clk);
      tap_capture_dr <= 0;
      for (int k = 0; k < n; k++) begin
         tap_shift_dr <= 1;
         tap_tdi <= d[k];
         @(posedge clk);
         v[k] = tap_tdo;
      end
      tap_shift_dr <= 0;
      tap_update_dr <= 1;
      @(posedge clk);
      tap_update_dr <= 0;
      @(posedge clk);
   endtask
   // start instruction, then a short visit to run-test/idle
   task automatic launch;
      tap_instr <= MSBC_I_START;
      @(posedge clk);
      tap_rti <= 1;
      @(posedge clk);
      tap_rti <= 0;
      repeat (3) @(posedge clk);
   endtask
   // serial order must be ascending over unskipped engines
   task automatic ord_chk(input logic [47:0] s);
      int n;
      n = 0;
      for (int i = 0; i < 48; i++) if (!s[i]) begin
         chk("order", (n < q.size()) ? q[n] : 99, i);
         n++;
      end
      chk("count", q.size(), n);
      q = {};
   endtask
   // timeout and serial start monitor
   always @(posedge clk) begin
      cyc++;
      if (cyc > 6000) begin
         err_count++;
         close_out;
      end
      ps <= eng_start;
      if (mon) for (int i = 0; i < 48; i++) if (eng_start[i] && !ps[i]) begin
         if (q.size() > 0) chk("prev done", eng_done[q[$]], 1);
         q.push_back(i);
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk("init_en rst", init_en, 1);
      apb(0, 12'h008, 0);
      chk("mode rst", r, 32'h2);
      apb(0, 12'h040, 0);
      chk("unmapped", {se, r}, 33'h1_0000_0000);
      // parallel run programmed over the tap
      sk = 48'({$random(seed), $random(seed)}) & ~48'h1;
      fail_pat <= 48'({$random(seed), $random(seed)}) & ~48'h1;
      lat <= 4'($random(seed)) & 4'h7;
      dr(MSBC_I_SKIP, 48, sk);
      dr(MSBC_I_MODE, 4, 48'h1);
      apb(0, 12'h000, 0);
      chk("skip lo", r, sk[31:0]);
      apb(0, 12'h008, 0);
      chk("mode", r, 32'h1);
      launch;
      chk("par start", eng_start, ~sk);
      tap_tlr <= 1;
      repeat (3) @(posedge clk);
      tap_tlr <= 0;
      chk("tlr run", eng_start, ~sk);
      repeat (30) @(posedge clk);
      dr(MSBC_I_RESULT, 2, 0);
      chk("summary", v[1:0], rsum(fail_pat, sk));
      dr(MSBC_I_DONE, 48, 0);
      chk("done vec", v & ~sk, ~sk);
      dr(MSBC_I_FAIL, 48, 0);
      chk("fail vec", v, fail_pat & ~sk);
      tap_instr <= MSBC_I_ABORT;
      repeat (3) @(posedge clk);
      chk("abort", eng_start, 0);
      apb(0, 12'h004, 0);
      chk("skip kept", r, sk[47:32]);
      // serial run over apb settings, fresh after abort
      sk = 48'({$random(seed), $random(seed)});
      apb(1, 12'h000, sk[31:0]);
      apb(1, 12'h004, 32'(sk[47:32]));
      apb(1, 12'h008, 0);
      chk("init off", init_en, 0);
      mon <= 1;
      launch;
      repeat (900) @(posedge clk);
      ord_chk(sk);
      apb(1, 12'h00c, 2);
      chk("cmd abort", eng_start, 0);
      // default test ignores parallel mode and mask
      apb(1, 12'h008, 1);
      fail_pat <= 0;
      run_default_test <= 1;
      repeat (900) @(posedge clk);
      ord_chk(0);
      dr(MSBC_I_RESULT, 2, 0);
      chk("def summary", v[1:0], 2'b10);
      apb(1, 12'h00c, 2);
      run_default_test <= 0;
      mon <= 0;
      @(posedge clk); // a launch needs both request levels low at one edge first
      run_default_init <= 1;
      repeat (4) @(posedge clk);
      chk("init en", init_en, 1);
      chk("init start", eng_start[0], 1);
      dr(MSBC_I_SKIP, 48, ~48'h10);
      dr(MSBC_I_DIAG, 16, 48'($random(seed)));
      chk("diag chain", v[8:1], 8'h5a);
      close_out;
   end
endmodule // tb_top
